// [shared/rtc_ctrl_pkg.sv]
package rtc_ctrl_pkg;
    // register offsets (device byte addresses) and the register reset value
    localparam logic [7:0] IRQ_OUTPUT_CONTROL_ADDR = 8'h08;
    localparam logic [7:0] TAMPER_CONFIG_ADDR      = 8'h09;
    localparam logic [7:0] CRYSTAL_LOAD_TRIM_ADDR  = 8'h0a;
    localparam logic [7:0] REG_RESET               = 8'h00;

    // irq_output_control fields
    localparam int FREQ_SELECT_LSB    = 0;
    localparam int PIN_OFF_BAT_BIT    = 4;
    localparam int LOW_POWER_BIT      = 5;
    localparam int ALARM_ENABLE_BIT   = 6;
    localparam int ALARM_PULSE_BIT    = 7;
    // tamper_config fields, then the crystal load trim field
    localparam int SAMPLE_RATE_LSB    = 0;
    localparam int DEBOUNCE_LSB       = 2;
    localparam int TAMPER_ENABLE_BIT  = 4;
    localparam int HALT_ON_EVENT_BIT  = 5;
    localparam int EVOUT_OFF_BAT_BIT  = 6;
    localparam int PULLUP_DISABLE_BIT = 7;
    localparam int CAP_TRIM_LSB       = 0;

    // timing: the oscillator enable arrives as a one-cycle tick at 32768 Hz
    localparam int OSC_HZ           = 32768;
    localparam int PRESCALE_W       = 20;
    localparam int PULSE_MS         = 250;
    localparam int PULSE_OSC_TICKS  = OSC_HZ * PULSE_MS / 1000;
    localparam int DEB1_US          = 3900;
    localparam int DEB2_US          = 15625;
    localparam int DEB3_US          = 31250;
    localparam int DEB1_TICKS       = (OSC_HZ * DEB1_US + 999999) / 1000000;
    localparam int DEB2_TICKS       = (OSC_HZ * DEB2_US + 999999) / 1000000;
    localparam int DEB3_TICKS       = (OSC_HZ * DEB3_US + 999999) / 1000000;
    localparam int TICKS_2HZ        = OSC_HZ / 2;
    localparam int TICKS_1HZ        = OSC_HZ;
    localparam int TICKS_QHZ        = OSC_HZ * 4;
    localparam logic [5:0] CAP_MID  = 6'h00;

    typedef struct packed {
        logic       alarm_pulse_mode;
        logic       alarm_enable;
        logic       low_power_switchover;
        logic       pin_off_in_battery;
        logic [3:0] freq_select;
    } irq_ctrl_t;

    typedef struct packed {
        logic       pullup_disable;
        logic       event_out_off_in_battery;
        logic       halt_on_event;
        logic       tamper_enable;
        logic [1:0] event_debounce_time;
        logic [1:0] event_sample_rate;
    } tamper_cfg_t;

    typedef enum logic [1:0] {
        EV_IDLE   = 2'b00,
        EV_FILTER = 2'b01,
        EV_HELD   = 2'b11
    } ev_state_t;
endpackage

// [tb/host_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
module host_pin_model (
    input  wire logic clk_i,
    input  wire logic irq_oe_i,
    input  wire logic det_oe_i,
    output logic      irq_pin_o,
    output logic      det_pin_o,
    output int        irq_falls_o
);
    logic prev_q = 1'b1;
    // open-drain pins with board pull-ups, so a released pin reads high
    assign irq_pin_o = irq_oe_i ? 1'b0 : 1'b1;
    assign det_pin_o = det_oe_i ? 1'b0 : 1'b1;
    // edges counted on the wire, not on the enable, as the host sees them
    always @(posedge clk_i) begin
        if (prev_q && !irq_pin_o) irq_falls_o <= irq_falls_o + 1;
        prev_q <= irq_pin_o;
    end
endmodule
`default_nettype wire

// [tb/rtc_irq_event_trim_control_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module rtc_irq_event_trim_control_tb_top;
    import rtc_ctrl_pkg::*;
    typedef struct packed {logic [7:0] a, d, e;} row_t;
    logic clk = 0, rst = 1, tick = 0, wr = 0, tw = 0, am = 0, acl = 0, ecl = 0;
    logic tin = 0, vb = 0, vt = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rd, v;
    logic onb, irqo, irqoe, deoe, pen, af, ef, halt, irq_pin, det_pin;
    logic [5:0] cx1, cx2;
    logic tdiv = 1'b0;
    int nt = 0, falls, f0, miscompares = 0, total_checks = 0;
    row_t rows [7] = '{'{8'h08, 8'h5a, 8'h5a}, '{8'h09, 8'hc3, 8'hc3},
        '{8'h0a, 8'h3f, 8'h3f}, '{8'h0a, 8'hff, 8'hff}, '{8'h0b, 8'h77, 8'h00},
        '{8'h09, 8'h2c, 8'h2c}, '{8'h08, 8'h00, 8'h00}};

    rtc_irq_event_trim_control DUT (.CLK_SYS_I(clk), .RST_I(rst), .OSC_TICK_I(tick),
        .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wd), .REG_RDATA_O(rd),
        .TIME_WRITE_I(tw), .ALARM_MATCH_I(am), .ALARM_FLAG_CLR_I(acl),
        .EVENT_FLAG_CLR_I(ecl), .TAMPER_INPUT_I(tin), .VDD_BELOW_BAT_I(vb),
        .VDD_BELOW_TRIP_I(vt), .ON_BATTERY_O(onb), .IRQ_FREQ_O(irqo),
        .IRQ_FREQ_OE_O(irqoe), .TAMPER_DETECT_OE_O(deoe), .PULLUP_EN_O(pen),
        .ALARM_FLAG_O(af), .EVENT_FLAG_O(ef), .COUNT_HALT_O(halt),
        .CAP_TRIM_X1_O(cx1), .CAP_TRIM_X2_O(cx2));
    host_pin_model PARTNER (.clk_i(clk), .irq_oe_i(irqoe), .det_oe_i(deoe),
        .irq_pin_o(irq_pin), .det_pin_o(det_pin), .irq_falls_o(falls));

    always #10 clk = ~clk;
    // oscillator tick every other cycle: time compressed so 250 ms and 2 Hz fit
    always @(negedge clk) begin
        tdiv <= ~tdiv;
        tick <= tdiv;
        if (tick) nt <= nt + 1;
    end

    task automatic print_verdict;
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1;
        addr = a;
        wd = d;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        d = rd;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1;
        @(negedge clk);
        s = 0;
        @(negedge clk);
    endtask
    task automatic wtick(input int n);
        int s;
        s = nt;
        while (nt < s + n) @(negedge clk);
    endtask
    task automatic do_reset;
        rst = 1;
        repeat (5) @(negedge clk);
        rst = 0;
        rreg(IRQ_OUTPUT_CONTROL_ADDR, v);
        chk(v, REG_RESET);
        rreg(TAMPER_CONFIG_ADDR, v);
        chk(v, REG_RESET);
        rreg(CRYSTAL_LOAD_TRIM_ADDR, v);
        chk(v, REG_RESET);
        chk({onb, irqoe, deoe, pen, af, ef, halt, irqo}, 8'h10);
        chk({2'h0, cx1}, {2'h0, CAP_MID});
        chk({2'h0, cx2}, {2'h0, CAP_MID});
        $display("done: reset");
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        do_reset();
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rreg(rows[i].a, v);
            chk(v, rows[i].e);
            if (rows[i].a == TAMPER_CONFIG_ADDR) chkb(pen, ~rows[i].d[7]);
            if (rows[i].a == CRYSTAL_LOAD_TRIM_ADDR) begin
                chk({2'h0, cx1}, {2'h0, rows[i].d[5:0]});
                chk({2'h0, cx2}, {2'h0, rows[i].d[5:0]});
            end
        end
        $display("done: register rows");
        wreg(8'h08, 8'h00);
        pulse(am);
        chk({6'h00, af, irqoe}, 8'h00);
        wreg(8'h08, 8'h40);
        pulse(am);
        chkb(af, 1'b1);
        wtick(50);
        chkb(irq_pin, 1'b0);
        pulse(acl);
        @(negedge clk);
        chk({6'h00, af, irqoe}, 8'h00);
        $display("done: standard alarm");
        wreg(8'h08, 8'h43);
        pulse(am);
        chkb(af, 1'b0);
        f0 = falls;
        wtick(256);
        chkb((falls - f0) inside {[7:9]}, 1'b1);
        pulse(acl);
        wreg(8'h08, 8'h00);
        wtick(4);
        f0 = falls;
        wtick(64);
        chkb(falls == f0, 1'b1);
        $display("done: frequency out");
        vb = 1;
        wreg(8'h08, 8'h40);
        chkb(onb, 1'b0);
        vt = 1;
        repeat (2) @(negedge clk);
        chkb(onb, 1'b1);
        vt = 0;
        wreg(8'h08, 8'h70);
        @(negedge clk);
        chkb(onb, 1'b1);
        pulse(am);
        chk({6'h00, af, irqoe}, 8'h02);
        wreg(8'h08, 8'h60);
        @(negedge clk);
        chkb(irqoe, 1'b1);
        wreg(8'h09, 8'h50);
        tin = 1;
        wtick(4);
        chk({6'h00, ef, deoe}, 8'h02);
        vb = 0;
        tin = 0;
        pulse(ecl);
        pulse(acl);
        $display("done: battery");
        wreg(8'h09, 8'h00);
        tin = 1;
        wtick(4);
        chkb(ef, 1'b0);
        wreg(8'h09, 8'h20);
        wtick(4);
        chk({6'h00, ef, halt}, 8'h00);
        wreg(8'h09, 8'h1c);
        wtick(4);
        chkb(ef, 1'b1);
        tin = 0;
        pulse(ecl);
        wreg(8'h09, 8'h30);
        tin = 1;
        wtick(4);
        chk({5'h00, ef, det_pin, halt}, 8'h05);
        tin = 0;
        pulse(tw);
        chkb(halt, 1'b0);
        rreg(8'h09, v);
        chk(v, 8'h10);
        $display("done: tamper");
        pulse(ecl);
        wreg(8'h09, 8'h15);
        tin = 1;
        wtick(64);
        chkb(ef, 1'b0);
        wtick(TICKS_2HZ + DEB1_TICKS);
        chkb(ef, 1'b1);
        tin = 0;
        pulse(ecl);
        $display("done: sampled tamper");
        wreg(8'h08, 8'hc0);
        pulse(am);
        wtick(PULSE_OSC_TICKS - 2);
        chkb(irqoe, 1'b1);
        wtick(4);
        chk({6'h00, af, irqoe}, 8'h02);
        pulse(am);
        wtick(2);
        chkb(irqoe, 1'b1);
        $display("done: pulse alarm");
        do_reset();
        print_verdict();
    end
endmodule
`default_nettype wire

// [verilog/rtc_irq_event_trim_control.sv]
// Summary of operation
// [R01] four-bit freq_select picks square wave on shared pin; zero turns it off (code 1 drives a one-cycle low pulse per tick, not a square)
// [R02] nonzero freq_select drives frequency on pin and disables the alarm
// [R03] pin_off_in_battery with backup supply releases the shared pin entirely
// [R04] switchover: bit 0 needs both comparators, bit 1 only the hysteresis one
// [R05] alarm matching and signalling work only while alarm_enable is one
// [R06] pulse mode: each alarm gives one 250 ms low pulse, repeats every match
// [R07] standard mode: alarm holds pin low until alarm flag is cleared
// [R08] sample rate: 00 continuous, 01 2 Hz, 10 1 Hz, 11 quarter hertz
// [R09] debounce: 00 none, 01 3.9 ms, 10 15.625 ms, 11 31.25 ms
// [R10] debounce applies only in sampled modes, ignored when continuous
// [R11] tamper detection only while tamper enable bit is one
// [R12] halt_on_event plus detected event stops the timekeeping counters
// [R13] a valid time write resumes counting and clears halt_on_event
// [R14] halt on event only works with tamper detection enabled
// [R15] event_out_off_in_battery with backup supply keeps detect output idle
// [R16] pullup_disable one turns tamper pull-up off, zero turns it on
// [R17] six-bit trim to both arrays, top bit inverted, code zero mid-scale
// [R18] tamper input high sets event flag and pulls detect output low
// [R19] enabled alarm match sets the alarm flag
// [R20] frequencies and sample ticks from one shared prescaler; debounce counts ticks in its own counter
`timescale 1ns/100ps
`default_nettype none
module rtc_irq_event_trim_control (
    input  wire logic       CLK_SYS_I,
    input  wire logic       RST_I,
    input  wire logic       OSC_TICK_I,
    input  wire logic       REG_WR_I,
    input  wire logic [7:0] REG_ADDR_I,
    input  wire logic [7:0] REG_WDATA_I,
    output logic      [7:0] REG_RDATA_O,
    input  wire logic       TIME_WRITE_I,
    input  wire logic       ALARM_MATCH_I,
    input  wire logic       ALARM_FLAG_CLR_I,
    input  wire logic       EVENT_FLAG_CLR_I,
    input  wire logic       TAMPER_INPUT_I,
    input  wire logic       VDD_BELOW_BAT_I,
    input  wire logic       VDD_BELOW_TRIP_I,
    output logic            ON_BATTERY_O,
    output logic            IRQ_FREQ_O,
    output logic            IRQ_FREQ_OE_O,
    output logic            TAMPER_DETECT_OE_O,
    output logic            PULLUP_EN_O,
    output logic            ALARM_FLAG_O,
    output logic            EVENT_FLAG_O,
    output logic            COUNT_HALT_O,
    output logic      [5:0] CAP_TRIM_X1_O,
    output logic      [5:0] CAP_TRIM_X2_O
);
    import rtc_ctrl_pkg::*;

    irq_ctrl_t   irq_reg, irq_next;
    tamper_cfg_t ev_reg, ev_next;
    logic [7:0]  trim_reg, trim_next;
    logic [PRESCALE_W-1:0] pre_reg, pre_next;
    logic        alarm_flag_reg, alarm_flag_next;
    logic        event_flag_reg, event_flag_next;
    logic        halt_reg, halt_next;
    logic        halt_next_ev;
    logic        bat_reg, bat_next;
    logic [13:0] pulse_cnt_reg, pulse_cnt_next;
    logic [10:0] deb_cnt_reg, deb_cnt_next;
    ev_state_t   ev_state_reg, ev_state_next;
    logic        pin_o_reg, pin_o_next, pin_oe_reg, pin_oe_next;
    logic        det_oe_reg, det_oe_next, pull_reg, pull_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        alarm_hit, sample_tick, freq_wave;

    // selected rate is a prescaler bit; 32768 Hz is the tick itself
    function automatic logic freq_bit(input logic [3:0] sel, input logic [PRESCALE_W-1:0] p);
        unique case (sel)
            4'h2: freq_bit = p[2];
            4'h3: freq_bit = p[4];
            4'h4: freq_bit = p[8];
            4'h5: freq_bit = p[9];
            4'h6: freq_bit = p[10];
            4'h7: freq_bit = p[11];
            4'h8: freq_bit = p[12];
            4'h9: freq_bit = p[13];
            4'ha: freq_bit = p[14];
            4'hb: freq_bit = p[15];
            4'hc: freq_bit = p[16];
            4'hd: freq_bit = p[17];
            4'he: freq_bit = p[18];
            4'hf: freq_bit = p[19];
            default: freq_bit = 1'b1;
        endcase
    endfunction

    function automatic logic [10:0] deb_len(input logic [1:0] code);
        unique case (code)
            2'b01: deb_len = 11'(DEB1_TICKS);
            2'b10: deb_len = 11'(DEB2_TICKS);
            2'b11: deb_len = 11'(DEB3_TICKS);
            default: deb_len = 11'h000;
        endcase
    endfunction

    // top rate has no faster source than the tick: a narrow pulse, not a square
    always_comb begin
        freq_wave = 1'b1;
        if (irq_reg.freq_select == 4'h1) begin
            freq_wave = !OSC_TICK_I; // [R01]
        end else if (irq_reg.freq_select != 4'h0) begin
            freq_wave = freq_bit(irq_reg.freq_select, pre_reg); // [R01] [R20]
        end
        sample_tick = 1'b0;
        if (OSC_TICK_I) begin
            unique case (ev_reg.event_sample_rate) // [R08] [R20]
                2'b00: sample_tick = 1'b1;
                2'b01: sample_tick = (pre_reg[13:0] == 14'h3fff);
                2'b10: sample_tick = (pre_reg[14:0] == 15'h7fff);
                2'b11: sample_tick = (pre_reg[16:0] == 17'h1ffff);
            endcase
        end
        alarm_hit = ALARM_MATCH_I && irq_reg.alarm_enable
                    && (irq_reg.freq_select == 4'h0); // [R02] [R05]
    end

    always_comb begin
        irq_next  = irq_reg;
        ev_next   = ev_reg;
        trim_next = trim_reg;
        rdata_next = rdata_reg;
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                IRQ_OUTPUT_CONTROL_ADDR: irq_next = irq_ctrl_t'(REG_WDATA_I);
                TAMPER_CONFIG_ADDR:      ev_next  = tamper_cfg_t'(REG_WDATA_I);
                CRYSTAL_LOAD_TRIM_ADDR:  trim_next = REG_WDATA_I;
                default: ;
            endcase
        end
        if (TIME_WRITE_I) begin
            ev_next.halt_on_event = 1'b0; // [R13]
        end
        unique case (REG_ADDR_I)
            IRQ_OUTPUT_CONTROL_ADDR: rdata_next = irq_reg;
            TAMPER_CONFIG_ADDR:      rdata_next = ev_reg;
            CRYSTAL_LOAD_TRIM_ADDR:  rdata_next = trim_reg;
            default:                 rdata_next = 8'h00;
        endcase
    end

    // supply switchover and status flags; hardware set beats clear
    always_comb begin
        pre_next = pre_reg;
        if (OSC_TICK_I) begin
            pre_next = pre_reg + 1'b1; // [R20]
        end
        bat_next = irq_reg.low_power_switchover ? VDD_BELOW_BAT_I
                   : (VDD_BELOW_BAT_I && VDD_BELOW_TRIP_I); // [R04]
        alarm_flag_next = alarm_flag_reg;
        if (ALARM_FLAG_CLR_I) begin
            alarm_flag_next = 1'b0;
        end
        if (alarm_hit) begin
            alarm_flag_next = 1'b1; // [R19]
        end
        halt_next = halt_reg;
        if (TIME_WRITE_I) begin
            halt_next = 1'b0; // [R13]
        end
    end

    // tamper detector: sample, optional debounce, then latch
    always_comb begin
        ev_state_next   = ev_state_reg;
        deb_cnt_next    = deb_cnt_reg;
        halt_next_ev    = 1'b0;
        event_flag_next = event_flag_reg;
        if (EVENT_FLAG_CLR_I) begin
            event_flag_next = 1'b0;
        end
        if (!ev_reg.tamper_enable) begin
            ev_state_next = EV_IDLE; // [R11]
            deb_cnt_next  = 11'h000;
        end else begin
            unique case (ev_state_reg)
                EV_IDLE: begin
                    if (sample_tick && TAMPER_INPUT_I) begin
                        if (ev_reg.event_sample_rate == 2'b00
                            || ev_reg.event_debounce_time == 2'b00) begin // [R10]
                            ev_state_next = EV_HELD;
                        end else begin
                            ev_state_next = EV_FILTER;
                            deb_cnt_next  = deb_len(ev_reg.event_debounce_time); // [R09]
                        end
                    end
                end
                EV_FILTER: begin
                    if (!TAMPER_INPUT_I) begin
                        ev_state_next = EV_IDLE;
                    end else if (OSC_TICK_I) begin
                        if (deb_cnt_reg <= 11'h001) begin
                            ev_state_next = EV_HELD;
                        end else begin
                            deb_cnt_next = deb_cnt_reg - 11'h001;
                        end
                    end
                end
                EV_HELD: begin
                    if (!TAMPER_INPUT_I) begin
                        ev_state_next = EV_IDLE;
                    end
                end
            endcase
        end
        if (ev_state_next == EV_HELD && ev_state_reg != EV_HELD) begin
            event_flag_next = 1'b1; // [R18]
            if (ev_reg.halt_on_event && ev_reg.tamper_enable) begin
                halt_next_ev = 1'b1; // [R12] [R14]
            end
        end
    end

    // pin drivers: one-way buffers are modelled as open-drain lows
    always_comb begin
        pulse_cnt_next = pulse_cnt_reg;
        if (alarm_hit && irq_reg.alarm_pulse_mode) begin
            pulse_cnt_next = 14'(PULSE_OSC_TICKS); // [R06]
        end else if (OSC_TICK_I && pulse_cnt_reg != 14'h0000) begin
            pulse_cnt_next = pulse_cnt_reg - 14'h0001;
        end
        pin_o_next  = 1'b0;
        pin_oe_next = 1'b0;
        if (bat_reg && irq_reg.pin_off_in_battery) begin
            pin_oe_next = 1'b0; // [R03]
        end else if (irq_reg.freq_select != 4'h0) begin
            pin_oe_next = !freq_wave; // [R02]
        end else if (irq_reg.alarm_enable) begin
            if (irq_reg.alarm_pulse_mode) begin
                pin_oe_next = (pulse_cnt_next != 14'h0000); // [R06]
            end else begin
                pin_oe_next = alarm_flag_next; // [R07]
            end
        end
        det_oe_next = event_flag_next
                      && !(bat_reg && ev_reg.event_out_off_in_battery); // [R15] [R18]
        pull_next = !ev_reg.pullup_disable; // [R16]
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            irq_reg        <= irq_ctrl_t'(REG_RESET);
            ev_reg         <= tamper_cfg_t'(REG_RESET);
            trim_reg       <= REG_RESET;
            rdata_reg      <= 8'h00;
            pre_reg        <= '0;
            bat_reg        <= 1'b0;
            alarm_flag_reg <= 1'b0;
            event_flag_reg <= 1'b0;
            halt_reg       <= 1'b0;
            pulse_cnt_reg  <= 14'h0000;
            deb_cnt_reg    <= 11'h000;
            ev_state_reg   <= EV_IDLE;
            pin_o_reg      <= 1'b0;
            pin_oe_reg     <= 1'b0;
            det_oe_reg     <= 1'b0;
            pull_reg       <= 1'b1;
        end else begin
            irq_reg        <= irq_next;
            ev_reg         <= ev_next;
            trim_reg       <= trim_next;
            rdata_reg      <= rdata_next;
            pre_reg        <= pre_next;
            bat_reg        <= bat_next;
            alarm_flag_reg <= alarm_flag_next;
            event_flag_reg <= event_flag_next;
            halt_reg       <= halt_next | halt_next_ev; // [R12] [R14]
            pulse_cnt_reg  <= pulse_cnt_next;
            deb_cnt_reg    <= deb_cnt_next;
            ev_state_reg   <= ev_state_next;
            pin_o_reg      <= pin_o_next;
            pin_oe_reg     <= pin_oe_next;
            det_oe_reg     <= det_oe_next;
            pull_reg       <= pull_next;
        end
    end

    // trim word is passed as-is; the array inverts bit 5 for mid-scale zero
    assign CAP_TRIM_X1_O      = trim_reg[5:0]; // [R17]
    assign CAP_TRIM_X2_O      = trim_reg[5:0]; // [R17]
    assign REG_RDATA_O        = rdata_reg;
    assign ON_BATTERY_O       = bat_reg;
    assign IRQ_FREQ_O         = pin_o_reg;
    assign IRQ_FREQ_OE_O      = pin_oe_reg;
    assign TAMPER_DETECT_OE_O = det_oe_reg;
    assign PULLUP_EN_O        = pull_reg;
    assign ALARM_FLAG_O       = alarm_flag_reg;
    assign EVENT_FLAG_O       = event_flag_reg;
    assign COUNT_HALT_O       = halt_reg;

    property p_pulse_len;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        (alarm_hit && irq_reg.alarm_pulse_mode) |=> (pulse_cnt_reg == 14'(PULSE_OSC_TICKS));
    endproperty
    chk_alarm_pulse_load: assert property (p_pulse_len) else $error("pulse not loaded"); // [R06]
    chk_alarm_flag_set: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R19]
        alarm_hit |=> alarm_flag_reg) else $error("alarm flag missed");
    chk_alarm_off_freq: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R02]
        (irq_reg.freq_select != 4'h0 && ALARM_MATCH_I && !ALARM_FLAG_CLR_I)
        |=> (alarm_flag_reg == $past(alarm_flag_reg))) else $error("alarm with freq");
    chk_pin_battery_off: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R03]
        (bat_reg && irq_reg.pin_off_in_battery) |=> !pin_oe_reg) else $error("pin on in battery");
    chk_std_alarm_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R07]
        (irq_reg.freq_select == 4'h0 && irq_reg.alarm_enable && !irq_reg.alarm_pulse_mode
         && !bat_reg && alarm_flag_next) |=> pin_oe_reg) else $error("alarm low lost");
    chk_tamper_disabled: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R11]
        !ev_reg.tamper_enable |=> ev_state_reg == EV_IDLE) else $error("detect while off");
    chk_halt_resume: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R13]
        (TIME_WRITE_I && !halt_next_ev) |=> (!halt_reg && !ev_reg.halt_on_event))
        else $error("halt not cleared");
    chk_pullup_follow: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R16]
        ##1 (pull_reg == !$past(ev_reg.pullup_disable))) else $error("pullup wrong");
    chk_switchover: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // [R04]
        (!irq_reg.low_power_switchover && !VDD_BELOW_TRIP_I) |=> !bat_reg)
        else $error("switch without trip");
endmodule
`default_nettype wire
